//--- bga_pkg.sv
// Overview of operation
// R1: grant acknowledge only after the bus grant input is seen low.
// R2: address strobe line must be deasserted before ownership is taken.
// R3: both size acknowledge lines must be deasserted before ownership is taken.
// R4: shared grant acknowledge line must be deasserted before driving it.
// R5: host drives slave read/write select high to read, low to write.
// R6: with bus mode select 1, drive both size acknowledges after an access.
// R7: grant acknowledge is active low, released (not driven) while inactive.
// R8: system drives bus grant low to offer mastership.
// R9: all four ownership conditions are checked together in one cycle.
`default_nettype none
package bga_pkg;

    // ****************************************
    // states and timing
    // ****************************************
    typedef enum logic [3:0] {
        BGA_IDLE = 4'h1,
        BGA_WAIT = 4'h2,
        BGA_OWN  = 4'h4,
        BGA_REL  = 4'h8
    } bga_state_type;

    localparam int unsigned BGA_ACK_HOLD = 1;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic bus_grant_in_n;
        logic address_strobe_line_n;
        logic size_ack_low_n;
        logic size_ack_high_n;
        logic grant_acknowledge_n;
    } bga_bus_in_type;

    typedef struct packed {
        logic o;
        logic oe;
    } bga_pin_type;

endpackage : bga_pkg
`default_nettype wire

//--- bga_slave_ack.sv
`timescale 1ns/1ps
`default_nettype none
module bga_slave_ack
    import bga_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic        bus_mode_select_i,
    input  wire logic        access_done_i,
    input  wire logic        slave_rw_select_i,
    output var bga_pin_type  size_ack_low_o,
    output var bga_pin_type  size_ack_high_o,
    output logic             last_read_o
);
    logic ack_q;
    logic ack_d;
    logic rd_q;

    // R6: ack after access
    assign ack_d = bus_mode_select_i & access_done_i & ~ack_q;

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            ack_q <= 1'b0;
            rd_q  <= 1'b0;
        end else begin
            ack_q <= ack_d;
            // R5: direction latched
            if (access_done_i) begin
                rd_q <= slave_rw_select_i;
            end
        end
    end

    assign size_ack_low_o  = '{o: 1'b0, oe: ack_q};
    assign size_ack_high_o = '{o: 1'b0, oe: ack_q};
    assign last_read_o     = rd_q;

    // ****************************************
    // checks
    // ****************************************
    property p_ack_mode;
        @(posedge clock_i) disable iff (!rstn_i)
        (bus_mode_select_i && access_done_i && !ack_q) |=> size_ack_low_o.oe;
    endproperty
    a_ack_mode: assert property (p_ack_mode) else $error("ack missing"); // R6
    property p_ack_off;
        @(posedge clock_i) disable iff (!rstn_i)
        !$past(bus_mode_select_i) |-> !size_ack_high_o.oe;
    endproperty
    a_ack_off: assert property (p_ack_off) else $error("ack outside mode"); // R6
    c_ack: cover property (@(posedge clock_i) size_ack_low_o.oe);
endmodule // bga_slave_ack
`default_nettype wire

//--- bga_grant.sv
`timescale 1ns/1ps
`default_nettype none
module bga_grant
    import bga_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire bga_bus_in_type bus_i,
    input  wire logic        want_bus_i,
    input  wire logic        bus_mode_select_i,
    input  wire logic        access_done_i,
    input  wire logic        slave_rw_select_i,
    output var bga_pin_type  grant_acknowledge_o,
    output var bga_pin_type  size_ack_low_o,
    output var bga_pin_type  size_ack_high_o,
    output logic             owner_o,
    output logic             last_read_o
);
    // ****************************************
    // ownership conditions
    // ****************************************
    bga_state_type state_q;
    bga_state_type state_d;
    logic          grant_seen;
    logic          strobe_free;
    logic          slave_free;
    logic          ack_free;
    logic          all_free;
    logic          in_idle;
    logic          in_wait;
    logic          in_own;
    logic          in_rel;
    logic          take_bus;

    // R1: R8: grant low
    assign grant_seen  = ~bus_i.bus_grant_in_n;
    // R2: strobe released
    assign strobe_free = bus_i.address_strobe_line_n;
    // R3: slave off bus
    assign slave_free  = bus_i.size_ack_low_n & bus_i.size_ack_high_n;
    // R4: prior master gone
    assign ack_free    = bus_i.grant_acknowledge_n;
    // R9: all together
    assign all_free    = grant_seen & strobe_free & slave_free & ack_free;

    // ****************************************
    // state decode
    // ****************************************
    // one compare helper keeps the four decodes in_idle to in_rel alike
    function automatic logic bga_is(input bga_state_type s, input bga_state_type t);
        return (s == t);
    endfunction

    assign in_idle  = bga_is(state_q, BGA_IDLE);
    assign in_wait  = bga_is(state_q, BGA_WAIT);
    assign in_own   = bga_is(state_q, BGA_OWN);
    assign in_rel   = bga_is(state_q, BGA_REL);
    // R9: one cycle decides
    assign take_bus = in_wait & want_bus_i & all_free;

    always_comb begin
        state_d = state_q;
        case (state_q)
            BGA_IDLE: begin
                if (want_bus_i) begin
                    state_d = BGA_WAIT;
                end
            end
            BGA_WAIT: begin
                if (!want_bus_i) begin
                    state_d = BGA_IDLE;
                end else if (take_bus) begin
                    state_d = BGA_OWN;
                end
            end
            BGA_OWN: begin
                // hold until the job is over; grant may drop while owning
                if (!want_bus_i) begin
                    state_d = BGA_REL;
                end
            end
            BGA_REL: begin
                state_d = BGA_IDLE;
            end
            default: begin
                state_d = BGA_IDLE;
            end
        endcase
    end

    // ****************************************
    // state register
    // ****************************************
    // sync reset: pins released from the first reset edge
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            state_q <= BGA_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // pin drive
    // ****************************************
    // R7: low, else released
    assign grant_acknowledge_o = '{o: 1'b0, oe: in_own};
    assign owner_o             = in_own;

    // ****************************************
    // slave acknowledge
    // ****************************************
    // slave side runs apart from ownership
    bga_slave_ack u_ack (
        .clock_i           (clock_i),
        .rstn_i            (rstn_i),
        .bus_mode_select_i (bus_mode_select_i),
        .access_done_i     (access_done_i),
        .slave_rw_select_i (slave_rw_select_i),
        .size_ack_low_o    (size_ack_low_o),
        .size_ack_high_o   (size_ack_high_o),
        .last_read_o       (last_read_o)
    );

    // ****************************************
    // checks
    // ****************************************
    property p_need_grant;
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(grant_acknowledge_o.oe) |-> $past(grant_seen);
    endproperty
    a_need_grant: assert property (p_need_grant) else $error("ack without grant"); // R1
    property p_need_strobe;
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(grant_acknowledge_o.oe) |-> $past(strobe_free);
    endproperty
    a_need_strobe: assert property (p_need_strobe) else $error("strobe busy"); // R2
    property p_need_slave;
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(grant_acknowledge_o.oe) |-> $past(slave_free);
    endproperty
    a_need_slave: assert property (p_need_slave) else $error("slave on bus"); // R3
    property p_need_ack;
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(grant_acknowledge_o.oe) |-> $past(ack_free);
    endproperty
    a_need_ack: assert property (p_need_ack) else $error("other master on bus"); // R4
    property p_take;
        @(posedge clock_i) disable iff (!rstn_i)
        (state_q == BGA_WAIT && want_bus_i && all_free) |=> grant_acknowledge_o.oe;
    endproperty
    a_take: assert property (p_take) else $error("bus not taken"); // R9
    property p_release;
        @(posedge clock_i) disable iff (!rstn_i)
        (owner_o && !want_bus_i) |=> !grant_acknowledge_o.oe [*2];
    endproperty
    a_release: assert property (p_release) else $error("ack not released"); // R7
    property p_low;
        @(posedge clock_i) disable iff (!rstn_i)
        grant_acknowledge_o.oe |-> !grant_acknowledge_o.o;
    endproperty
    a_low: assert property (p_low) else $error("ack driven high"); // R7

    // per-condition blocking while waiting
    property p_block_grant;
        @(posedge clock_i) disable iff (!rstn_i)
        (in_wait && !grant_seen) |=> !grant_acknowledge_o.oe;
    endproperty
    a_block_grant: assert property (p_block_grant) else $error("taken without grant"); // R1

    property p_block_strobe;
        @(posedge clock_i) disable iff (!rstn_i)
        (in_wait && !strobe_free) |=> !grant_acknowledge_o.oe;
    endproperty
    a_block_strobe: assert property (p_block_strobe) else $error("taken while strobe busy"); // R2

    property p_block_slave;
        @(posedge clock_i) disable iff (!rstn_i)
        (in_wait && !slave_free) |=> !grant_acknowledge_o.oe;
    endproperty
    a_block_slave: assert property (p_block_slave) else $error("taken while slave on bus"); // R3

    property p_block_ack;
        @(posedge clock_i) disable iff (!rstn_i)
        (in_wait && !ack_free) |=> !grant_acknowledge_o.oe;
    endproperty
    a_block_ack: assert property (p_block_ack) else $error("taken while master on bus"); // R4

    // no interlock: a grant withdrawn while owning is not seen
    property p_hold;
        @(posedge clock_i) disable iff (!rstn_i)
        (in_own && want_bus_i) |=> grant_acknowledge_o.oe;
    endproperty
    a_hold: assert property (p_hold) else $error("ownership dropped early"); // R7

    property p_start_wait;
        @(posedge clock_i) disable iff (!rstn_i)
        (in_idle && want_bus_i) |=> in_wait && !grant_acknowledge_o.oe;
    endproperty
    a_start_wait: assert property (p_start_wait) else $error("bus taken unchecked"); // R9

    property p_onehot;
        @(posedge clock_i) disable iff (!rstn_i)
        $onehot(state_q);
    endproperty
    a_onehot: assert property (p_onehot) else $error("state not one-hot"); // R9

    property p_rel_once;
        @(posedge clock_i) disable iff (!rstn_i)
        in_rel |=> in_idle && !grant_acknowledge_o.oe;
    endproperty
    a_rel_once: assert property (p_rel_once) else $error("release not finished"); // R7

    property p_wait_leave;
        @(posedge clock_i) disable iff (!rstn_i)
        (in_wait && !want_bus_i) |=> in_idle && !grant_acknowledge_o.oe;
    endproperty
    a_wait_leave: assert property (p_wait_leave) else $error("request not dropped"); // R9

    property p_own_past;
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(owner_o) |-> $past(in_wait) && $past(want_bus_i);
    endproperty
    a_own_past: assert property (p_own_past) else $error("owned without wait"); // R9
    c_own: cover property (@(posedge clock_i) $rose(owner_o));
    c_wait: cover property (@(posedge clock_i) state_q == BGA_WAIT && !all_free);
    c_rel: cover property (@(posedge clock_i) state_q == BGA_REL);
    c_give_up: cover property (@(posedge clock_i) in_wait && !want_bus_i);
endmodule // bga_grant
`default_nettype wire

//--- bga_arb_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// arbiter, other master and other slave
// ****************************************
module bga_arb_model
    import bga_pkg::*;
(
    input  wire logic       grant_i,
    input  wire logic [3:0] other_i,
    input  wire bga_pin_type gack_i,
    input  wire bga_pin_type sack_lo_i,
    input  wire bga_pin_type sack_hi_i,
    output var bga_bus_in_type bus_o
);
    // grant offered low
    // shared lines: driven value while enabled, pulled high when released
    assign bus_o = '{
        bus_grant_in_n:        ~grant_i,
        address_strobe_line_n: ~other_i[0],
        size_ack_low_n:        ~other_i[1] & (sack_lo_i.oe ? sack_lo_i.o : 1'b1),
        size_ack_high_n:       ~other_i[2] & (sack_hi_i.oe ? sack_hi_i.o : 1'b1),
        grant_acknowledge_n:   ~other_i[3] & (gack_i.oe ? gack_i.o : 1'b1)
    };
endmodule // bga_arb_model
`default_nettype wire

//--- bus_grant_ack_and_slave_strobe_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
// ****************************************
// bench top
// ****************************************
module bus_grant_ack_and_slave_strobe_tb;
    import bga_pkg::*;
    logic           clock_i = 1'b0;
    logic           rstn_i  = 1'b0;
    logic           want    = 1'b0;
    logic           mode    = 1'b0;
    logic           done    = 1'b0;
    logic           rw      = 1'b0;
    logic           grant   = 1'b0;
    logic [3:0]     other   = 4'h0;
    bga_bus_in_type bus;
    bga_pin_type    gack, slo, shi;
    logic           owner, last_read;
    int             err_count = 0;
    int             n_checks  = 0;
    int             seed      = 63;
    int             k, b;
    always #50 clock_i = ~clock_i;
    bga_arb_model arb_u (.grant_i(grant), .other_i(other), .gack_i(gack),
        .sack_lo_i(slo), .sack_hi_i(shi), .bus_o(bus));
    bga_grant dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .bus_i(bus), .want_bus_i(want),
        .bus_mode_select_i(mode), .access_done_i(done), .slave_rw_select_i(rw),
        .grant_acknowledge_o(gack), .size_ack_low_o(slo), .size_ack_high_o(shi),
        .owner_o(owner), .last_read_o(last_read));
    // drives land just after the edge, clear of sampling
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        step(5);
        rstn_i <= 1'b1;
        // one ownership condition held false at a time
        for (k = 0; k < 5; k++) begin
            grant <= (k != 0);
            other <= (k == 0) ? 4'h0 : 4'h1 << (k - 1);
            want  <= 1'b1;
            step(3 + $unsigned($random(seed)) % 6);
            `CHK("blocked", 1'b0, gack.oe)
            grant <= 1'b1;
            other <= 4'h0;
            b = 0;
            while (owner !== 1'b1 && b < 4) begin
                step(1);
                b++;
            end
            `CHK("owner", 1'b1, owner)
            `CHK("gack_low", 2'b10, {gack.oe, gack.o})
            `CHK("gack_line", 1'b0, bus.grant_acknowledge_n)
            // grant withdrawn while owning: ownership holds until released
            grant <= 1'b0;
            step(1);
            `CHK("own_hold", 1'b1, owner)
            want <= 1'b0;
            step(3);
            `CHK("gack_off", 1'b0, gack.oe)
            $display("grant test %0d done", k);
        end
        // give up while blocked, own again, then reset while owning
        grant <= 1'b0;
        want  <= 1'b1;
        step(3);
        want  <= 1'b0;
        step(1);
        `CHK("give_up", 1'b0, gack.oe)
        step(2);
        grant <= 1'b1;
        want  <= 1'b1;
        step(2);
        `CHK("re_own", 1'b1, owner)
        rstn_i <= 1'b0;
        want   <= 1'b0;
        step(1);
        `CHK("rst_gack", 1'b0, gack.oe)
        `CHK("rst_owner", 1'b0, owner)
        rstn_i <= 1'b1;
        step(2);
        `CHK("rst_idle", 1'b0, gack.oe)
        $display("corner test done");
        // slave acks in mode 1, none in mode 0, random direction
        for (k = 0; k < 8; k++) begin
            mode <= k[0];
            rw   <= 1'($random(seed));
            done <= 1'b1;
            step(1);
            done <= 1'b0;
            `CHK("ack_lo", k[0], slo.oe)
            `CHK("ack_hi", k[0], shi.oe)
            `CHK("last_read", rw, last_read)
            step(BGA_ACK_HOLD);
            `CHK("ack_end", 1'b0, slo.oe)
        end
        // done held two cycles: the second falls in the ack cycle
        mode <= 1'b1;
        done <= 1'b1;
        step(1);
        `CHK("b2b_first", 1'b1, slo.oe)
        step(1);
        done <= 1'b0;
        `CHK("b2b_skip", 1'b0, slo.oe)
        step(1);
        `CHK("b2b_none", 1'b0, shi.oe)
        $display("slave ack test done");
        print_verdict();
    end
endmodule // bus_grant_ack_and_slave_strobe_tb
`default_nettype wire
